// ===== sync_ctl_defines.vh
// constants for the synchronization control block
`ifndef SYNC_CTL_DEFINES_VH
`define SYNC_CTL_DEFINES_VH

// apb register byte addresses
`define ADDR_CTRL        12'h000
`define ADDR_STRETCH     12'h004
`define ADDR_STATUS      12'h008

// control register fields
`define CTRL_HOLD_BIT    0
`define CTRL_DECIM_BIT   1
`define CTRL_TEST_LO     2
`define CTRL_TEST_HI     3
`define CTRL_WIDTH       4
`define CTRL_RESET       4'h0

// test modes
`define TEST_OFF         2'h0
`define TEST_RAMP        2'h1
`define TEST_FLASH       2'h2

// stretch field
`define STRETCH_WIDTH    4
`define STRETCH_RESET    4'h0

// decimation divider
`define DIV_WIDTH        4

// status register layout
`define STAT_SYNC_BIT    0
`define STAT_HOLD_BIT    1
`define STAT_TEST_BIT    2
`define STAT_VALID_BIT   3
`define STAT_DIV_LO      4
`define STAT_DIV_HI      7

`define ZERO32           32'h00000000

`endif

// ===== sync_stretch.v
// synchronizer and stretcher for the external synchronization pulse
`include "sync_ctl_defines.vh"

module sync_stretch (
  input  wire                      clk_sys_i,
  input  wire                      reset_n_i,
  input  wire                      sync_in_pos_i,
  input  wire [`STRETCH_WIDTH-1:0] stretch_i,
  output reg                       sync_int_o,
  output reg                       sync_fall_o
);

  reg                      meta;
  reg                      stage2;
  reg                      stage3;
  reg                      level;
  reg [`STRETCH_WIDTH-1:0] extra;

  // ----------------------------------------
  // three stage synchronizer, change on agreement
  // ----------------------------------------
  always @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      meta   <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
      level  <= 1'b0;
    end else begin
      meta   <= sync_in_pos_i;                              // RULE_11
      stage2 <= meta;
      stage3 <= stage2;
      if (stage2 == stage3)
        level <= stage3;                                    // RULE_11
    end
  end

  // ----------------------------------------
  // stretch by 0..15 extra cycles
  // ----------------------------------------
  always @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      extra       <= `STRETCH_RESET;
      sync_int_o  <= 1'b0;
      sync_fall_o <= 1'b0;
    end else begin
      sync_fall_o <= 1'b0;
      if (level) begin
        sync_int_o <= 1'b1;
        extra      <= stretch_i;                            // RULE_02
      end else if (sync_int_o) begin
        if (extra == `STRETCH_RESET) begin
          sync_int_o  <= 1'b0;
          sync_fall_o <= 1'b1;
        end else begin
          extra <= extra - 1'b1;                            // RULE_02
        end
      end
    end
  end

endmodule

// ===== sync_ctl.v
// synchronization control with apb registers, clock hold and divider reset
//
// Notes on behaviour
// RULE_01 - controller holds sync high long enough
// RULE_02 - internal pulse stretched by 0 to 15
// RULE_03 - hold mode stops clocks during pulse
// RULE_04 - run mode realigns clocks at falling edge
// RULE_05 - controller pulses sync after mode changes
// RULE_06 - other settings need no sync pulse
// RULE_07 - test resources reinitialised on sync after entry
// RULE_08 - leaving test resumes output immediately
// RULE_09 - sync resets decimation dividers, data invalid
// RULE_10 - reset selects clock hold behaviour
// RULE_11 - sync input passes a synchronizer
`include "sync_ctl_defines.vh"

module sync_ctl (
  input  wire        clk_sys_i,
  input  wire        reset_n_i,
  input  wire        sync_in_pos_i,
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [11:0] paddr_i,
  input  wire [31:0] pwdata_i,
  output reg  [31:0] prdata_o,
  output reg         pready_o,
  output reg         pslverr_o,
  output reg         clk_run_o,
  output reg         realign_o,
  output reg         divider_reset_o,
  output reg         test_init_o,
  output reg         data_valid_o
);

  reg  [`CTRL_WIDTH-1:0]    ctrl;
  reg  [`STRETCH_WIDTH-1:0] stretch;
  reg  [`DIV_WIDTH-1:0]     div_count;
  reg                       test_pending;
  reg                       test_ready;
  wire                      sync_int;
  wire                      sync_fall;
  wire                      hold_sel;
  wire                      decim_on;
  wire [1:0]                test_mode;
  wire                      in_test;
  wire                      access;
  wire                      wr_commit;
  reg  [31:0]               next_rdata;
  reg                       next_err;

  assign hold_sel  = ctrl[`CTRL_HOLD_BIT];
  assign decim_on  = ctrl[`CTRL_DECIM_BIT];
  assign test_mode = ctrl[`CTRL_TEST_HI:`CTRL_TEST_LO];
  assign in_test   = (test_mode != `TEST_OFF);
  assign access    = psel_i & penable_i & ~pready_o;
  assign wr_commit = psel_i & penable_i & pready_o & pwrite_i;

  // address decode used by the error path; the read path decodes with its own case
  function is_mapped;
    input [11:0] addr;
    begin
      is_mapped = (addr == `ADDR_CTRL) ||
                  (addr == `ADDR_STRETCH) ||
                  (addr == `ADDR_STATUS);
    end
  endfunction

  sync_stretch u_stretch (
    .clk_sys_i     (clk_sys_i),
    .reset_n_i     (reset_n_i),
    .sync_in_pos_i (sync_in_pos_i),
    .stretch_i     (stretch),
    .sync_int_o    (sync_int),
    .sync_fall_o   (sync_fall)
  );

  // ----------------------------------------
  // apb slave, one wait state
  // ----------------------------------------
  always @* begin
    next_rdata = `ZERO32;
    next_err   = ~is_mapped(paddr_i);
    case (paddr_i)
      `ADDR_CTRL:    next_rdata[`CTRL_WIDTH-1:0] = ctrl;
      `ADDR_STRETCH: next_rdata[`STRETCH_WIDTH-1:0] = stretch;
      `ADDR_STATUS: begin
        next_rdata[`STAT_SYNC_BIT]             = sync_int;
        next_rdata[`STAT_HOLD_BIT]             = ~clk_run_o;
        next_rdata[`STAT_TEST_BIT]             = test_ready;
        next_rdata[`STAT_VALID_BIT]            = data_valid_o;
        next_rdata[`STAT_DIV_HI:`STAT_DIV_LO]  = div_count;
      end
      default:       next_rdata = `ZERO32;
    endcase
  end

  // ----------------------------------------
  // apb handshake, one wait state
  // ----------------------------------------
  always @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= access;
      pslverr_o <= access & next_err;
    end
  end

  // ----------------------------------------
  // read data, loaded in the wait state so it stands with pready
  // ----------------------------------------
  always @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      prdata_o <= `ZERO32;
    end else if (access && !pwrite_i) begin
      prdata_o <= next_rdata;
    end
  end

  // ----------------------------------------
  // control register, taken at the completing edge
  // ----------------------------------------
  always @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      ctrl <= `CTRL_RESET;                                   // RULE_10
    end else if (wr_commit && paddr_i == `ADDR_CTRL) begin
      ctrl <= pwdata_i[`CTRL_WIDTH-1:0];                     // RULE_06
    end
  end

  // ----------------------------------------
  // stretch register
  // ----------------------------------------
  always @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      stretch <= `STRETCH_RESET;
    end else if (wr_commit && paddr_i == `ADDR_STRETCH) begin
      stretch <= pwdata_i[`STRETCH_WIDTH-1:0];               // RULE_02
    end
  end

  // ----------------------------------------
  // clock hold, only in hold mode
  // ----------------------------------------
  always @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      clk_run_o <= 1'b1;
    end else begin
      clk_run_o <= ~(sync_int & ~hold_sel);                  // RULE_03
    end
  end

  // ----------------------------------------
  // realignment pulse at the falling edge, run mode
  // ----------------------------------------
  always @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      realign_o <= 1'b0;
    end else begin
      realign_o <= sync_fall & hold_sel;                     // RULE_04
    end
  end

  // ----------------------------------------
  // decimation divider, reset by sync
  // ----------------------------------------
  always @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      div_count       <= {`DIV_WIDTH{1'b0}};
      divider_reset_o <= 1'b0;
    end else begin
      divider_reset_o <= decim_on & sync_int;                // RULE_09
      if (sync_int || !decim_on)
        div_count <= {`DIV_WIDTH{1'b0}};                     // RULE_09
      else
        div_count <= div_count + 1'b1;
    end
  end

  // ----------------------------------------
  // test resources
  // ----------------------------------------
  always @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      test_pending <= 1'b0;
      test_ready   <= 1'b0;
      test_init_o  <= 1'b0;
    end else begin
      test_init_o <= 1'b0;
      if (!in_test) begin
        test_pending <= 1'b0;
        test_ready   <= 1'b0;                                // RULE_08
      end else if (!test_ready && !test_pending) begin
        test_pending <= 1'b1;
      end else if (test_pending && sync_fall) begin
        test_pending <= 1'b0;
        test_ready   <= 1'b1;                                // RULE_07
        test_init_o  <= 1'b1;                                // RULE_07
      end
    end
  end

  // ----------------------------------------
  // data validity: low while dividers reset or test not ready
  // ----------------------------------------
  always @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      data_valid_o <= 1'b1;
    end else begin
      data_valid_o <= ~(decim_on & sync_int) & (~in_test | test_ready); // RULE_09
    end
  end

endmodule

// ===== sync_ctl_asserts.sv
// checker for the synchronization control block
module sync_ctl_chk (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic sync_in_pos_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic clk_run_o,
  input wire logic realign_o,
  input wire logic divider_reset_o,
  input wire logic test_init_o,
  input wire logic data_valid_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  a_ready_pulse: assert property (pready_o |=> !pready_o) else $error("pready too long");
  a_ready_wait: assert property (psel_i && penable_i && !pready_o |=> pready_o) else $error("no pready");
  a_err_ready: assert property (pslverr_o |-> pready_o) else $error("pslverr without pready");
  a_realign_pulse: assert property (realign_o |=> !realign_o) else $error("realign too long");
  a_realign_run: assert property (realign_o |-> clk_run_o) else $error("realign with clocks held");
  a_init_pulse: assert property (test_init_o |=> !test_init_o) else $error("test init too long");
  a_div_invalid: assert property (divider_reset_o |-> !data_valid_o) else $error("data valid in reset");
  a_sync_late: assert property ($rose(sync_in_pos_i) && clk_run_o |=> clk_run_o [*2])
    else $error("sync not synchronized");
  cover property ($fell(clk_run_o));
  cover property (realign_o);
  cover property (divider_reset_o);
  cover property (test_init_o);
endmodule
bind sync_ctl sync_ctl_chk i_chk (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .sync_in_pos_i(sync_in_pos_i),
  .psel_i(psel_i), .penable_i(penable_i), .pready_o(pready_o), .pslverr_o(pslverr_o), .clk_run_o(clk_run_o),
  .realign_o(realign_o), .divider_reset_o(divider_reset_o), .test_init_o(test_init_o),
  .data_valid_o(data_valid_o));

// ===== ctl_partner.sv
// controller model that issues the external sync pulse
module ctl_partner #(parameter int min_sync_cycles = 4) (
  input  wire logic clk_sys_i,
  input  wire logic go_i,
  input  var  int   len_i,
  output logic      sync_in_pos_o = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  int n = 0;
  always @(posedge clk_sys_i) begin
    if (go_i) n <= (len_i < min_sync_cycles) ? min_sync_cycles : len_i;
    else if (n > 0) n <= n - 1;
    sync_in_pos_o <= go_i || n > 1;
  end
endmodule

// ===== adc_sync_resync_control_bench.sv
// self-checking bench for the synchronization control block
module adc_sync_resync_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i = 1'b0, reset_n_i = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, go = 1'b0, err;
  logic [11:0] pa = 12'h000;
  logic [31:0] pwd = 32'h00000000, rd;
  wire logic [31:0] prd;
  wire logic sync, rdy, serr, run, rlg, divr, tini, dval;
  int n_fail = 0, comparisons = 0, len = 5, c[5], q[$] = '{0, 15, 0}, tm[2] = '{4, 8};
  always #2.5 clk_sys_i = ~clk_sys_i;
  sync_ctl i_dut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .sync_in_pos_i(sync), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd), .pready_o(rdy),
    .pslverr_o(serr), .clk_run_o(run), .realign_o(rlg), .divider_reset_o(divr), .test_init_o(tini),
    .data_valid_o(dval));
  ctl_partner i_ctl (.clk_sys_i(clk_sys_i), .go_i(go), .len_i(len), .sync_in_pos_o(sync));
  always @(posedge clk_sys_i) begin
    c[0] += (run === 1'b0);
    c[1] += (rlg === 1'b1);
    c[2] += (divr === 1'b1);
    c[3] += (dval === 1'b0);
    c[4] += (tini === 1'b1);
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task conclude;
    if (n_fail == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    {psel, pen, pwr, pa, pwd} <= {2'b10, w, a, d};
    @(posedge clk_sys_i);
    pen <= 1'b1;
    do @(posedge clk_sys_i); while (rdy !== 1'b1);
    {rd, err} = {prd, serr};
    {psel, pen} <= 2'b00;
  endtask
  task pulse;
    c = '{default: 0};
    @(posedge clk_sys_i);
    go <= 1'b1;
    @(posedge clk_sys_i);
    go <= 1'b0;
    repeat (40) @(posedge clk_sys_i);
  endtask
  initial begin
    void'($urandom(66));
    q[2] = $urandom_range(14, 1);
    repeat (6) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    apb(0, 12'h000, 0);
    chk(rd, 0);
    apb(0, 12'h00C, 0);
    chk({rd[30:0], err}, 1);
    apb(1, 12'h000, 32'hFFFFFFF0);
    apb(0, 12'h000, 0);
    chk(rd, 0);
    foreach (q[i]) begin
      apb(1, 12'h004, q[i]);
      apb(0, 12'h004, 0);
      chk(rd, q[i]);
      pulse;
      chk(c[0], len + q[i]);
      chk(c[0] >= len - 1, 1);
    end
    apb(1, 12'h000, 1);
    pulse;
    chk(c[0], 0);
    chk(c[1], 1);
    apb(1, 12'h000, 2);
    pulse;
    chk({c[2] > 0, c[3] > 0}, 3);
    foreach (tm[i]) begin
      apb(1, 12'h000, tm[i]);
      repeat (2) @(posedge clk_sys_i);
      chk(dval, 0);
      pulse;
      chk({c[4], dval}, 3);
      apb(1, 12'h000, 0);
      repeat (2) @(posedge clk_sys_i);
      chk(dval, 1);
    end
    apb(1, 12'h004, 7);
    repeat (2) @(posedge clk_sys_i);
    chk({run, dval}, 3);
    conclude;
  end
  initial begin
    #20000;
    n_fail++;
    conclude;
  end
endmodule
